// File: shared/cbs_pkg.sv
package cbs_pkg;
  // address space and flash layout
  localparam int unsigned ADDR_W        = 16;
  localparam logic [15:0] BOOT_WIN_TOP  = 16'h1fff;
  localparam int unsigned SECTOR_BYTES  = 128;
  localparam int unsigned SECTOR_SHIFT  = $clog2(SECTOR_BYTES);
  localparam int unsigned USER_BYTES    = 65536;
  localparam int unsigned SECTOR_COUNT  = USER_BYTES / SECTOR_BYTES;
  localparam int unsigned SECTOR_W      = $clog2(SECTOR_COUNT);

  // flash config bits
  localparam int unsigned CFG_SEL_BIT   = 0;
  localparam int unsigned CFG_SOFT_BIT  = 1;
  localparam logic [1:0]  CFG_BOOT      = 2'h0;
  localparam logic [1:0]  CFG_SOFT_RST  = 2'h2;

  // vectors
  localparam logic [15:0] RESET_VEC     = 16'h0000;
  localparam logic [15:0] BOD_VEC       = 16'h004b;

  // watchdog control register
  localparam logic [7:0]  WDOG_RST      = 8'h00;
  localparam logic [7:0]  WDOG_KEEP     = 8'h04;

  // timing
  localparam int unsigned CLK_HZ        = 100000000;
  localparam int unsigned AUTOBAUD_MS   = 400;
  localparam int unsigned AUTOBAUD_CYC  = AUTOBAUD_MS * (CLK_HZ / 1000);
  localparam int unsigned BOD_FILT_CYC  = 4;
  localparam int unsigned BOD_CNT_W     = 3;
  localparam int unsigned ABAUD_CNT_W   = 26;

  typedef enum logic [1:0] {
    CBS_BOOT_WAIT = 2'h0,
    CBS_BOOT_PROG = 2'h1,
    CBS_BOOT_EMUL = 2'h3,
    CBS_BOOT_USER = 2'h2
  } cbs_boot_e;
endpackage

// File: logic/cbs_bod_filter.sv
`timescale 1ns/1ns
module cbs_bod_filter
  import cbs_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // supply monitor
  input  wire logic supply_low,
  output logic      bod_active
);
  logic [BOD_CNT_W-1:0] cnt_ff;
  logic [BOD_CNT_W-1:0] nxt_cnt;
  logic                 act_ff;
  logic                 nxt_act;

  // count consecutive low samples, saturating at the filter length
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!supply_low) begin
      nxt_cnt = '0;
    end else if (cnt_ff < BOD_CNT_W'(BOD_FILT_CYC)) begin
      nxt_cnt = cnt_ff + BOD_CNT_W'(1);
    end
    nxt_act = (nxt_cnt == BOD_CNT_W'(BOD_FILT_CYC)); // see R11
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      act_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      act_ff <= nxt_act;
    end
  end

  assign bod_active = act_ff;

  a_bod_needs_four: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R11
    $rose(bod_active) |-> $past(supply_low, 1) && $past(supply_low, 2)
                          && $past(supply_low, 3) && $past(supply_low, 4))
    else $error("brown-out active before four low samples");
endmodule

// File: logic/cbs_bank_reset_ctrl.sv
// Operation
// R1: user flash splits into 128-byte erase sectors; index is address over 128.
// R2: boot block overlays lowest 8 kB when enabled; higher fetches use user block.
// R3: low window maps to boot only when soft reset and bank select bits are 00.
// R4: user code clears the soft reset bit before calling boot programming routines.
// R5: software must not clear bank select while running inside the low window.
// R6: power-on or pin reset forces both bank bits to zero, boot runs.
// R7: boot autobaud times out after 400 ms; without emulation flag, soft reset.
// R8: soft reset on bit 0-to-1 edge; pc goes to 0000, bits become 10.
// R9: soft reset keeps watchdog control bit 2 and RAM; other registers reset.
// R10: watchdog and brown-out resets clear bank select, keep soft reset bit.
// R11: brown-out acts only after four consecutive low-supply clock periods.
// R12: with brown-out interrupt enabled, brown-out raises interrupt to 004B.
// R13: without brown-out interrupt enable, brown-out resets processor to 0000.
// R14: software clears brown-out interrupt enable after servicing the interrupt.
// R15: clearing the enable while brown-out persists causes a brown-out reset.
// R16: power-off flag sets at initial power-up and holds until software clears.
// R17: reset pin held high through oscillator start plus two machine cycles.
// R18: system resets leave on-chip RAM unchanged; RAM undefined after power-up.
// R19: bank bit writes apply to the fetch decoded in the same cycle onward.
`timescale 1ns/1ns
module cbs_bank_reset_ctrl
  import cbs_pkg::*;
#(
  parameter int unsigned AUTOBAUD_CYCLES = AUTOBAUD_CYC
) (
  // clock and power-on reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // reset sources
  input  wire logic                ext_reset_pin,
  input  wire logic                supply_low,
  input  wire logic                wdt_timeout,
  // software register writes
  input  wire logic                cfg_wr,
  input  wire logic [1:0]          cfg_wdata,
  input  wire logic                irq_en_wr,
  input  wire logic                irq_en_wdata,
  input  wire logic                pwr_flag_clr,
  input  wire logic                wdog_wr,
  input  wire logic [7:0]          wdog_wdata,
  // boot firmware status
  input  wire logic                autobaud_ok,
  input  wire logic                emul_flag,
  // fetch and erase address paths
  input  wire logic                fetch_req,
  input  wire logic [ADDR_W-1:0]   fetch_addr,
  input  wire logic                erase_req,
  input  wire logic [ADDR_W-1:0]   erase_addr,
  // register state
  output logic [1:0]               flash_config_reg,
  output logic                     brownout_irq_enable,
  output logic                     power_off_flag,
  output logic [7:0]               watchdog_control_reg,
  // reset and interrupt to the core
  output logic                     cpu_reset,
  output logic                     sfr_reset,
  output logic                     bod_irq,
  output logic [ADDR_W-1:0]        pc_vector,
  // mapping results
  output logic                     fetch_valid,
  output logic                     fetch_from_boot,
  output logic [ADDR_W-1:0]        fetch_phys_addr,
  output logic                     erase_valid,
  output logic [SECTOR_W-1:0]      erase_sector,
  // boot status
  output logic                     in_system_programming,
  output logic                     emul_mode
);
  logic                     bod_active;
  logic [1:0]               cfg_ff,   nxt_cfg;
  logic                     irqen_ff, nxt_irqen;
  logic                     pwrf_ff,  nxt_pwrf;
  logic [7:0]               wdog_ff,  nxt_wdog;
  logic                     crst_ff,  nxt_crst;
  logic                     srst_ff,  nxt_srst;
  logic                     birq_ff,  nxt_birq;
  logic [ADDR_W-1:0]        vec_ff,   nxt_vec;
  logic                     bact_ff,  nxt_bact;
  logic                     bcond_ff, nxt_bcond;
  logic                     fv_ff,    nxt_fv;
  logic                     fb_ff,    nxt_fb;
  logic [ADDR_W-1:0]        fa_ff,    nxt_fa;
  logic                     ev_ff,    nxt_ev;
  logic [SECTOR_W-1:0]      es_ff,    nxt_es;
  cbs_boot_e                st_ff,    nxt_st;
  logic [ABAUD_CNT_W-1:0]   cnt_ff,   nxt_cnt;
  logic                     bod_rst_cond;
  logic                     bod_rst_evt;
  logic                     hw_rst;
  logic                     handoff;
  logic                     soft_evt;

  cbs_bod_filter u_bod (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .supply_low (supply_low),
    .bod_active (bod_active)
  );

  // boot handoff sequencer, restarted by power-on and the reset pin
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    handoff = 1'b0;
    if (ext_reset_pin) begin
      nxt_st  = CBS_BOOT_WAIT;
      nxt_cnt = '0;
    end else begin
      case (st_ff)
        CBS_BOOT_WAIT: begin
          if (autobaud_ok) begin
            nxt_st = CBS_BOOT_PROG;
          end else if (cnt_ff == ABAUD_CNT_W'(AUTOBAUD_CYCLES - 1)) begin // see R7
            if (emul_flag) begin
              nxt_st = CBS_BOOT_EMUL;
            end else begin
              nxt_st  = CBS_BOOT_USER;
              handoff = 1'b1;
            end
          end else begin
            nxt_cnt = cnt_ff + ABAUD_CNT_W'(1);
          end
        end
        CBS_BOOT_PROG: nxt_st = CBS_BOOT_PROG;
        CBS_BOOT_EMUL: nxt_st = CBS_BOOT_EMUL;
        CBS_BOOT_USER: nxt_st = CBS_BOOT_USER;
        default:       nxt_st = CBS_BOOT_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= CBS_BOOT_WAIT;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // reset sources and bank bits
  always_comb begin
    nxt_bact     = bod_active;
    bod_rst_cond = bod_active && !irqen_ff;                        // see R13 R15
    nxt_bcond    = bod_rst_cond;
    bod_rst_evt  = bod_rst_cond && !bcond_ff;
    hw_rst       = wdt_timeout || bod_rst_evt;
    soft_evt     = handoff ||
                   (cfg_wr && cfg_wdata[CFG_SOFT_BIT] && !cfg_ff[CFG_SOFT_BIT]); // see R8
    nxt_cfg   = cfg_ff;
    nxt_irqen = irqen_ff;
    nxt_wdog  = wdog_ff;
    nxt_pwrf  = pwrf_ff && !pwr_flag_clr;                          // see R16
    nxt_crst  = ext_reset_pin || hw_rst || soft_evt;
    nxt_srst  = nxt_crst;                                          // see R18
    nxt_birq  = bod_active && !bact_ff && irqen_ff;                // see R12
    nxt_vec   = vec_ff;
    if (ext_reset_pin) begin
      nxt_cfg   = CFG_BOOT;                                        // see R6
      nxt_irqen = 1'b0;
      nxt_wdog  = WDOG_RST;
    end else if (hw_rst) begin
      nxt_cfg[CFG_SEL_BIT] = 1'b0;                                 // see R10
      nxt_irqen = 1'b0;
      nxt_wdog  = WDOG_RST;
    end else if (soft_evt) begin
      nxt_cfg   = CFG_SOFT_RST;                                    // see R8
      nxt_irqen = 1'b0;
      nxt_wdog  = wdog_ff & WDOG_KEEP;                             // see R9
    end else begin
      if (cfg_wr) begin
        nxt_cfg = cfg_wdata;
      end
      if (irq_en_wr) begin
        nxt_irqen = irq_en_wdata;
      end
      if (wdog_wr) begin
        nxt_wdog = wdog_wdata;
      end
    end
    if (nxt_crst) begin
      nxt_vec  = RESET_VEC;                                        // see R13
      nxt_birq = 1'b0;
    end else if (nxt_birq) begin
      nxt_vec  = BOD_VEC;                                          // see R12
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= CFG_BOOT;
      irqen_ff <= 1'b0;
      pwrf_ff  <= 1'b1;
      wdog_ff  <= WDOG_RST;
      crst_ff  <= 1'b1;
      srst_ff  <= 1'b1;
      birq_ff  <= 1'b0;
      vec_ff   <= RESET_VEC;
      bact_ff  <= 1'b0;
      bcond_ff <= 1'b0;
    end else begin
      cfg_ff   <= nxt_cfg;
      irqen_ff <= nxt_irqen;
      pwrf_ff  <= nxt_pwrf;
      wdog_ff  <= nxt_wdog;
      crst_ff  <= nxt_crst;
      srst_ff  <= nxt_srst;
      birq_ff  <= nxt_birq;
      vec_ff   <= nxt_vec;
      bact_ff  <= nxt_bact;
      bcond_ff <= nxt_bcond;
    end
  end

  // fetch and erase decode, against the bank bits being written this cycle
  always_comb begin
    nxt_fv = fetch_req;
    nxt_fa = fetch_addr;
    nxt_fb = fetch_req && (fetch_addr <= BOOT_WIN_TOP)           // see R2
             && (nxt_cfg == CFG_BOOT);                             // see R3 R19
    nxt_ev = erase_req;
    nxt_es = erase_addr[SECTOR_SHIFT +: SECTOR_W];                 // see R1
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fv_ff <= 1'b0;
      fb_ff <= 1'b0;
      fa_ff <= '0;
      ev_ff <= 1'b0;
      es_ff <= '0;
    end else begin
      fv_ff <= nxt_fv;
      fb_ff <= nxt_fb;
      fa_ff <= nxt_fa;
      ev_ff <= nxt_ev;
      es_ff <= nxt_es;
    end
  end

  assign flash_config_reg      = cfg_ff;
  assign brownout_irq_enable   = irqen_ff;
  assign power_off_flag        = pwrf_ff;
  assign watchdog_control_reg  = wdog_ff;
  assign cpu_reset             = crst_ff;
  assign sfr_reset             = srst_ff;
  assign bod_irq               = birq_ff;
  assign pc_vector             = vec_ff;
  assign fetch_valid           = fv_ff;
  assign fetch_from_boot       = fb_ff;
  assign fetch_phys_addr       = fa_ff;
  assign erase_valid           = ev_ff;
  assign erase_sector          = es_ff;
  assign in_system_programming = (st_ff == CBS_BOOT_PROG);
  assign emul_mode             = (st_ff == CBS_BOOT_EMUL);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pin_forces_boot: assert property (ext_reset_pin |=> flash_config_reg == CFG_BOOT && cpu_reset) // see R6
    else $error("pin reset did not force boot mapping");
  a_soft_rst_bits: assert property ( // see R8
    !ext_reset_pin && !wdt_timeout && !bod_rst_evt && cfg_wr && cfg_wdata[CFG_SOFT_BIT]
      && !flash_config_reg[CFG_SOFT_BIT]
    |=> flash_config_reg == CFG_SOFT_RST && cpu_reset && pc_vector == RESET_VEC)
    else $error("soft reset did not set bits to 10");
  a_soft_keeps_wdt: assert property ( // see R9
    !ext_reset_pin && !hw_rst && soft_evt
    |=> watchdog_control_reg == ($past(watchdog_control_reg) & WDOG_KEEP))
    else $error("soft reset lost watchdog bit 2");
  a_wdt_keeps_soft: assert property ( // see R10
    !ext_reset_pin && wdt_timeout
    |=> !flash_config_reg[CFG_SEL_BIT]
        && flash_config_reg[CFG_SOFT_BIT] == $past(flash_config_reg[CFG_SOFT_BIT]))
    else $error("watchdog reset changed soft reset bit");
  a_bod_irq_vec: assert property ( // see R12
    $rose(bod_irq) |-> pc_vector == BOD_VEC && $past(brownout_irq_enable) && !cpu_reset)
    else $error("brown-out interrupt without enable or wrong vector");
  a_bod_resets: assert property ( // see R13 R15
    $rose(bod_active && !brownout_irq_enable) |=> cpu_reset && pc_vector == RESET_VEC)
    else $error("brown-out without enable did not reset");
  a_pof_sticky: assert property (!power_off_flag |=> !power_off_flag) // see R16
    else $error("power-off flag set after power-up");
  a_fetch_map: assert property ( // see R2 R3 R19
    fetch_req |=> fetch_valid && fetch_from_boot ==
      (($past(fetch_addr) <= BOOT_WIN_TOP) && flash_config_reg == CFG_BOOT))
    else $error("fetch mapped to wrong block");
  a_erase_sector: assert property ( // see R1
    erase_req |=> erase_valid && erase_sector == $past(erase_addr[SECTOR_SHIFT +: SECTOR_W]))
    else $error("wrong erase sector");
  a_handoff_soft: assert property ( // see R7
    handoff && !ext_reset_pin && !hw_rst |=> flash_config_reg == CFG_SOFT_RST && cpu_reset)
    else $error("autobaud timeout did not hand off");

  c_soft_reset: cover property (soft_evt && !handoff);
  c_bod_irq:    cover property ($rose(bod_irq));
  c_bod_reset:  cover property (bod_rst_evt);
  c_prog_mode:  cover property ($rose(in_system_programming));
endmodule

// File: tb/cbs_reset_src.sv
`timescale 1ns/1ns
module cbs_reset_src (
  // clock
  input  wire logic clk_sys,
  // reset pin and supply monitor outputs
  output logic      ext_reset_pin,
  output logic      supply_low
);
  initial begin
    ext_reset_pin = 1'b0;
    supply_low    = 1'b0;
  end

  // pin held well past two machine cycles, never shorter than three clocks
  task automatic pin_reset(input int n);
    @(negedge clk_sys);
    ext_reset_pin = 1'b1;
    repeat ((n < 3) ? 3 : n) @(negedge clk_sys);
    ext_reset_pin = 1'b0;
  endtask

  // supply level changes only at the falling edge
  task automatic set_supply(input logic v);
    @(negedge clk_sys);
    supply_low = v;
  endtask
endmodule

// File: tb/cbs_bank_reset_ctrl_tb.sv
`timescale 1ns/1ns
module cbs_bank_reset_ctrl_tb;
  import cbs_pkg::*;
  localparam int unsigned ABAUD = 20;
  logic                clk_sys, rst_n, ext_reset_pin, supply_low, wdt_timeout;
  logic                cfg_wr, irq_en_wr, irq_en_wdata, pwr_flag_clr, wdog_wr;
  logic                autobaud_ok, emul_flag;
  logic                fetch_req, erase_req, brownout_irq_enable, power_off_flag;
  logic                cpu_reset, sfr_reset, bod_irq, fetch_valid, fetch_from_boot;
  logic                erase_valid, in_system_programming, emul_mode;
  logic [1:0]          cfg_wdata, flash_config_reg;
  logic [7:0]          wdog_wdata, watchdog_control_reg;
  logic [ADDR_W-1:0]   fetch_addr, erase_addr, pc_vector, fetch_phys_addr;
  logic [SECTOR_W-1:0] erase_sector;
  int                  n_errors, tests_run, cycles;

  cbs_reset_src src (.clk_sys(clk_sys), .ext_reset_pin(ext_reset_pin), .supply_low(supply_low));

  cbs_bank_reset_ctrl #(.AUTOBAUD_CYCLES(ABAUD)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ext_reset_pin(ext_reset_pin),
    .supply_low(supply_low), .wdt_timeout(wdt_timeout), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .irq_en_wr(irq_en_wr), .irq_en_wdata(irq_en_wdata),
    .pwr_flag_clr(pwr_flag_clr), .wdog_wr(wdog_wr), .wdog_wdata(wdog_wdata),
    .autobaud_ok(autobaud_ok),
    .emul_flag(emul_flag), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .erase_req(erase_req), .erase_addr(erase_addr), .flash_config_reg(flash_config_reg),
    .brownout_irq_enable(brownout_irq_enable), .power_off_flag(power_off_flag),
    .watchdog_control_reg(watchdog_control_reg), .cpu_reset(cpu_reset),
    .sfr_reset(sfr_reset), .bod_irq(bod_irq), .pc_vector(pc_vector),
    .fetch_valid(fetch_valid), .fetch_from_boot(fetch_from_boot),
    .fetch_phys_addr(fetch_phys_addr), .erase_valid(erase_valid),
    .erase_sector(erase_sector), .in_system_programming(in_system_programming),
    .emul_mode(emul_mode)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well above the length of the sequence
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t run did not finish in time", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // strobes rise at one falling edge and drop at the next; outputs are read then
  task automatic wr_cfg(input logic [1:0] d);
    @(negedge clk_sys);
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask

  task automatic wr_irq_en(input logic d);
    @(negedge clk_sys);
    irq_en_wdata = d;
    irq_en_wr = 1'b1;
    @(negedge clk_sys);
    irq_en_wr = 1'b0;
  endtask

  task automatic wr_wdog(input logic [7:0] d);
    @(negedge clk_sys);
    wdog_wdata = d;
    wdog_wr = 1'b1;
    @(negedge clk_sys);
    wdog_wr = 1'b0;
  endtask

  task automatic wdt_pulse();
    @(negedge clk_sys);
    wdt_timeout = 1'b1;
    @(negedge clk_sys);
    wdt_timeout = 1'b0;
  endtask

  task automatic fetch(input logic [15:0] a, input logic boot);
    @(negedge clk_sys);
    fetch_addr = a;
    fetch_req = 1'b1;
    @(negedge clk_sys);
    fetch_req = 1'b0;
    chk({15'h0, fetch_valid}, 16'h1, "fetch valid");
    chk({15'h0, fetch_from_boot}, {15'h0, boot}, "fetch source");
    chk(fetch_phys_addr, a, "fetch physical address");
  endtask

  task automatic erase(input logic [15:0] a, input logic [15:0] sector);
    @(negedge clk_sys);
    erase_addr = a;
    erase_req = 1'b1;
    @(negedge clk_sys);
    erase_req = 1'b0;
    chk({15'h0, erase_valid}, 16'h1, "erase valid");
    chk({7'h0, erase_sector}, sector, "erase sector");
  endtask

  // bounded wait for a reset pulse from the device
  task automatic wait_rst(input int n);
    for (int i = 0; i < n && cpu_reset !== 1'b1; i++) @(negedge clk_sys);
    chk({15'h0, cpu_reset}, 16'h1, "reset pulse");
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_errors);
  endtask

  initial begin
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    rst_n = 1'b0;
    wdt_timeout = 1'b0;
    cfg_wr = 1'b0;
    irq_en_wr = 1'b0;
    irq_en_wdata = 1'b0;
    pwr_flag_clr = 1'b0;
    wdog_wr = 1'b0;
    fetch_req = 1'b0;
    erase_req = 1'b0;
    cfg_wdata = 2'h0;
    wdog_wdata = 8'h00;
    fetch_addr = 16'h0000;
    erase_addr = 16'h0000;
    autobaud_ok = 1'b1;
    emul_flag = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk({14'h0, flash_config_reg}, 16'h0, "bank bits after power-on");
    chk({15'h0, power_off_flag}, 16'h1, "power-off flag");
    chk({15'h0, in_system_programming}, 16'h1, "programming mode after autobaud");
    end_test("power_on");
    fetch(16'h1fff, 1'b1);
    fetch(16'h2000, 1'b0);
    erase(16'hff80, 16'h01ff);
    erase(16'h0080, 16'h0001);
    erase(16'h007f, 16'h0000);
    wr_cfg(2'h1);
    fetch(16'h0000, 1'b0);
    // writer runs above the low window; the fetch at 0100, in the same cycle as the write, sees the new mapping
    @(negedge clk_sys);
    cfg_wdata = 2'h0;
    cfg_wr = 1'b1;
    fetch_addr = 16'h0100;
    fetch_req = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    fetch_req = 1'b0;
    chk({15'h0, fetch_from_boot}, 16'h1, "fetch after bank write");
    end_test("mapping");
    wr_wdog(8'hff);
    wr_irq_en(1'b1);
    wr_cfg(2'h2);
    chk({15'h0, cpu_reset}, 16'h1, "soft reset pulse");
    chk({15'h0, sfr_reset}, 16'h1, "register reset pulse");
    chk({14'h0, flash_config_reg}, 16'h2, "bank bits after soft reset");
    chk(pc_vector, RESET_VEC, "soft reset vector");
    chk({8'h0, watchdog_control_reg}, 16'h0004, "watchdog control kept bit");
    chk({15'h0, brownout_irq_enable}, 16'h0, "irq enable reset");
    fetch(16'h0000, 1'b0);
    wr_cfg(2'h3);
    chk({15'h0, cpu_reset}, 16'h0, "second set is a plain write");
    end_test("soft_reset");
    wdt_pulse();
    chk({15'h0, cpu_reset}, 16'h1, "watchdog reset pulse");
    chk({14'h0, flash_config_reg}, 16'h2, "watchdog keeps soft bit");
    wr_cfg(2'h1);
    wdt_pulse();
    chk({14'h0, flash_config_reg}, 16'h0, "watchdog clears select");
    fetch(16'h0010, 1'b1);
    end_test("watchdog");
    wr_cfg(2'h3);
    wr_cfg(2'h3);
    chk({14'h0, flash_config_reg}, 16'h3, "select set before brown-out");
    src.set_supply(1'b1);
    repeat (2) @(negedge clk_sys);
    src.set_supply(1'b0);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys);
      chk({15'h0, cpu_reset}, 16'h0, "short sag ignored");
    end
    src.set_supply(1'b1);
    repeat (4) @(negedge clk_sys);
    chk({15'h0, cpu_reset}, 16'h0, "no reset before filter");
    @(negedge clk_sys);
    chk({15'h0, cpu_reset}, 16'h1, "brown-out reset");
    chk(pc_vector, RESET_VEC, "brown-out reset vector");
    chk({14'h0, flash_config_reg}, 16'h2, "brown-out bank effect");
    src.set_supply(1'b0);
    end_test("brownout_reset");
    wr_irq_en(1'b1);
    src.set_supply(1'b1);
    repeat (5) @(negedge clk_sys);
    chk({15'h0, bod_irq}, 16'h1, "brown-out interrupt");
    chk(pc_vector, BOD_VEC, "interrupt vector");
    chk({15'h0, cpu_reset}, 16'h0, "no reset with irq enabled");
    wr_irq_en(1'b0);
    wait_rst(3);
    chk(pc_vector, RESET_VEC, "reset vector after enable cleared");
    src.set_supply(1'b0);
    end_test("brownout_irq");
    @(negedge clk_sys);
    pwr_flag_clr = 1'b1;
    @(negedge clk_sys);
    pwr_flag_clr = 1'b0;
    chk({15'h0, power_off_flag}, 16'h0, "power-off flag cleared");
    autobaud_ok = 1'b0;
    src.pin_reset(4);
    chk({14'h0, flash_config_reg}, 16'h0, "bank bits after pin reset");
    chk({15'h0, power_off_flag}, 16'h0, "flag kept by pin reset");
    repeat (ABAUD / 2) @(negedge clk_sys);
    chk({14'h0, flash_config_reg}, 16'h0, "boot still waiting");
    wait_rst(ABAUD + 10);
    chk({14'h0, flash_config_reg}, 16'h2, "handoff to user");
    emul_flag = 1'b1;
    src.pin_reset(4);
    repeat (ABAUD + 10) @(negedge clk_sys);
    chk({15'h0, emul_mode}, 16'h1, "emulation entered");
    chk({14'h0, flash_config_reg}, 16'h0, "no handoff in emulation");
    end_test("boot_handoff");
    complete_run();
  end
endmodule
